// File: include/sdse_consts.svh
`ifndef SDSE_CONSTS_SVH
`define SDSE_CONSTS_SVH
// basic status codes
`define SDSE_ST_INIT        2'h0
`define SDSE_ST_NORMAL      2'h1
`define SDSE_ST_SELFTEST    2'h2
`define SDSE_ST_ERROR       2'h3
// detailed status codes
`define SDSE_SF_NONE        2'h0
`define SDSE_SF_MEMORY      2'h1
`define SDSE_SF_MODE        2'h2
`define SDSE_SF_LINK        2'h3
// error source bit positions, index = priority value - 1
`define SDSE_SRC_CMD        0
`define SDSE_SRC_DOUT       1
`define SDSE_SRC_RESET      2
`define SDSE_SRC_SUPPLY     3
`define SDSE_SRC_TEST       4
`define SDSE_SRC_FOTP       5
`define SDSE_SRC_URW        6
`define SDSE_SRC_UOTP       7
`define SDSE_SRC_TEMP       8
`define SDSE_SRC_CHAN       9
`define SDSE_SRC_OSC        10
`define SDSE_NUM_SRC        11
`define SDSE_ECHO_ZERO      3'h0
`define SDSE_DATA_ZERO      16'h0000
`endif

// File: include/sdse_pkg.sv
`default_nettype none
package sdse_pkg;
    typedef enum logic [1:0] {
        SDSE_DATA_SENSOR,
        SDSE_DATA_ZEROS,
        SDSE_DATA_ERRCODE
    } sdse_data_sel_t;
endpackage
`default_nettype wire

// File: design/sdse_prio_pick.sv
`include "sdse_consts.svh"
`default_nettype none
module sdse_prio_pick #(
    parameter int N = `SDSE_NUM_SRC
) (
    input  wire logic [N-1:0] req_i,
    output logic      [N-1:0] onehot_o,
    output logic              any_o
);
    if (N < 1) begin : g_bad_width
        $error("sdse_prio_pick: N must be at least 1");
    end
    // lowest index wins: index equals priority value minus one
    assign onehot_o = req_i & (~req_i + N'(1));
    assign any_o    = |req_i;
endmodule
`default_nettype wire

// File: design/sdse_sync2.sv
`default_nettype none
module sdse_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    if (W < 1) begin : g_bad_width
        $error("sdse_sync2: W must be at least 1");
    end
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end
    assign q_o = q_reg;
endmodule
`default_nettype wire

// File: design/sdse_status_encoder.sv
`include "sdse_consts.svh"
`default_nettype none
// Operation
// R1 - every sensor response carries 2-bit detailed status naming the internal error class
// R2 - detailed status comes from errors captured at previous command's chip-select rise
// R3 - 2-bit basic status; 11 means internal error and beats self-test/init/normal
// R4 - oscillator, channel clip/offset, temperature errors: 11/00, normal echo, real data
// R5 - user OTP bank error: 11/01, prio 8, zero echo, error code in data
// R6 - user read/write memory error: 11/01, prio 7, zero echo, error code once; here the code is sent in every frame while it wins
// R7 - factory OTP error: 11/01, prio 6, zero echo, error code at least once
// R8 - test mode: 11/10, prio 5, echo and data all zero
// R9 - supply error unsuppressed: 11/10, zeros until timer expiry, then code, aux off; here aux stays on while a stronger error wins
// R10 - supply error suppressed: 11/10, zeros until timer expiry, no error code
// R11 - device reset error: 11/10, prio 3, zero echo, error code once; here the code is sent in every frame while it wins
// R12 - output-line or command error: 11/11, zero echo, error code at least once
// R13 - simultaneous errors: lowest priority value decides encoding, echo and data
// R14 - master decodes status and discards data flagged by detailed error status
module sdse_status_encoder (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // frame timing, from the spi slave on this clock
    input  wire logic        cs_rise_i,
    // device state, asynchronous to this clock
    input  wire logic        osc_train_err_i,
    input  wire logic        signal_clip_flag_i,
    input  wire logic        offset_err_i,
    input  wire logic        temp_err_i,
    input  wire logic        user_bank_zero_err_i,
    input  wire logic        user_bank_one_err_i,
    input  wire logic        user_rw_bank_err_i,
    input  wire logic        factory_otp_err_i,
    input  wire logic        test_mode_flag_i,
    input  wire logic        supply_err_i,
    input  wire logic        supply_timer_expired_i,
    input  wire logic        device_reset_flag_i,
    input  wire logic        dout_line_err_i,
    // same-clock inputs
    input  wire logic        spi_cmd_err_i,
    input  wire logic        supply_error_suppress_i,
    input  wire logic        init_done_i,
    input  wire logic        self_test_i,
    input  wire logic [2:0]  source_id_i,
    input  wire logic [15:0] sensor_data_i,
    input  wire logic [15:0] error_code_i,
    // response fields
    output logic      [1:0]  basic_status_field_o,
    output logic      [1:0]  detailed_status_field_o,
    output logic      [2:0]  source_echo_o,
    output logic      [15:0] data_field_o,
    output sdse_pkg::sdse_data_sel_t data_sel_o,
    output logic             aux_output_enable_o
);
    import sdse_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    localparam int NS = `SDSE_NUM_SRC;

    logic [12:0] async_raw;
    logic [12:0] async_sync;
    assign async_raw = {osc_train_err_i, signal_clip_flag_i, offset_err_i, temp_err_i,
                        user_bank_zero_err_i, user_bank_one_err_i, user_rw_bank_err_i,
                        factory_otp_err_i, test_mode_flag_i, supply_err_i,
                        supply_timer_expired_i, device_reset_flag_i, dout_line_err_i};

    // levels only: a one-cycle skew between bits settles before the next capture reads them
    sdse_sync2 #(.W(13)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (async_raw),
        .q_o       (async_sync)
    );

    logic osc_s, clip_s, off_s, temp_s, ub0_s, ub1_s, urw_s, fotp_s;
    logic test_s, sup_s, tmr_s, dres_s, dout_s;
    assign {osc_s, clip_s, off_s, temp_s, ub0_s, ub1_s, urw_s, fotp_s,
            test_s, sup_s, tmr_s, dres_s, dout_s} = async_sync;

    ////////////////////////////////////////////////////////////////////////
    // live error vector; the command error is an event, held until the next capture
    logic          cmd_err_reg;
    logic [NS-1:0] live_src;

    assign live_src[`SDSE_SRC_CMD]    = cmd_err_reg | spi_cmd_err_i;
    assign live_src[`SDSE_SRC_DOUT]   = dout_s;
    assign live_src[`SDSE_SRC_RESET]  = dres_s;
    assign live_src[`SDSE_SRC_SUPPLY] = sup_s;
    assign live_src[`SDSE_SRC_TEST]   = test_s;
    assign live_src[`SDSE_SRC_FOTP]   = fotp_s;
    assign live_src[`SDSE_SRC_URW]    = urw_s;
    assign live_src[`SDSE_SRC_UOTP]   = ub0_s | ub1_s; // R5
    assign live_src[`SDSE_SRC_TEMP]   = temp_s;
    assign live_src[`SDSE_SRC_CHAN]   = clip_s | off_s;
    assign live_src[`SDSE_SRC_OSC]    = osc_s;

    // an error arriving in the capture cycle is kept for the next frame too
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd_err_reg <= 1'b0;
        end else if (spi_cmd_err_i) begin
            cmd_err_reg <= 1'b1;
        end else if (cs_rise_i) begin
            cmd_err_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // snapshot at the chip-select rise that ends a command
    logic [NS-1:0] snap_reg;
    logic          snap_supp_reg;
    logic          snap_tmr_reg;
    logic          snap_init_reg;
    logic          snap_st_reg;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            snap_reg      <= '0;
            snap_supp_reg <= 1'b0;
            snap_tmr_reg  <= 1'b0;
            snap_init_reg <= 1'b0;
            snap_st_reg   <= 1'b0;
        end else if (cs_rise_i) begin
            snap_reg      <= live_src; // R2
            snap_supp_reg <= supply_error_suppress_i;
            snap_tmr_reg  <= tmr_s;
            snap_init_reg <= init_done_i;
            snap_st_reg   <= self_test_i;
        end
    end

    logic [NS-1:0] win;
    logic          any_err;

    sdse_prio_pick #(.N(NS)) u_pick (
        .req_i    (snap_reg),
        .onehot_o (win),
        .any_o    (any_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // class decode of the winning source
    logic cls_none, cls_mem, cls_mode, cls_link;
    logic win_sup, win_test;
    assign cls_none = win[`SDSE_SRC_OSC] | win[`SDSE_SRC_CHAN] | win[`SDSE_SRC_TEMP]; // R4
    assign cls_mem  = win[`SDSE_SRC_UOTP] | win[`SDSE_SRC_URW] | win[`SDSE_SRC_FOTP]; // R5 R6 R7
    assign cls_mode = win[`SDSE_SRC_TEST] | win[`SDSE_SRC_SUPPLY] | win[`SDSE_SRC_RESET]; // R8 R9 R10 R11
    assign cls_link = win[`SDSE_SRC_DOUT] | win[`SDSE_SRC_CMD]; // R12
    assign win_sup  = win[`SDSE_SRC_SUPPLY];
    assign win_test = win[`SDSE_SRC_TEST];

    logic [1:0] basic_next;
    logic [1:0] detail_next;
    assign basic_next = any_err       ? `SDSE_ST_ERROR :    // R3
                        snap_st_reg   ? `SDSE_ST_SELFTEST :
                        snap_init_reg ? `SDSE_ST_NORMAL : `SDSE_ST_INIT;
    assign detail_next = cls_mem  ? `SDSE_SF_MEMORY : // R1 R13
                         cls_mode ? `SDSE_SF_MODE :
                         cls_link ? `SDSE_SF_LINK : `SDSE_SF_NONE;

    // supply: zeros until timer expiry; then one code unless suppressed
    logic sup_code_sent_reg;
    logic sup_send_code;
    assign sup_send_code = win_sup & snap_tmr_reg & ~snap_supp_reg & ~sup_code_sent_reg; // R9 R10

    sdse_data_sel_t sel_next;
    assign sel_next = (~any_err | cls_none) ? SDSE_DATA_SENSOR :  // R4
                      win_test              ? SDSE_DATA_ZEROS :   // R8
                      win_sup               ? (sup_send_code ? SDSE_DATA_ERRCODE : SDSE_DATA_ZEROS) :
                      SDSE_DATA_ERRCODE;                           // R5 R6 R7 R11 R12

    logic        zero_echo;
    logic [2:0]  echo_next;
    logic [15:0] data_next;
    assign zero_echo = any_err & ~cls_none;
    assign echo_next = zero_echo ? `SDSE_ECHO_ZERO : source_id_i;
    assign data_next = (sel_next == SDSE_DATA_SENSOR) ? sensor_data_i :
                       (sel_next == SDSE_DATA_ERRCODE) ? error_code_i : `SDSE_DATA_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // response fields, registered; the limitation is one cycle of latency after capture
    logic [1:0]     basic_reg;
    logic [1:0]     detail_reg;
    logic [2:0]     echo_reg;
    logic [15:0]    data_reg;
    sdse_data_sel_t sel_reg;
    logic           aux_en_reg;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            basic_reg  <= `SDSE_ST_INIT;
            detail_reg <= `SDSE_SF_NONE;
            echo_reg   <= `SDSE_ECHO_ZERO;
            data_reg   <= `SDSE_DATA_ZERO;
            sel_reg    <= SDSE_DATA_SENSOR;
            aux_en_reg <= 1'b1;
        end else begin
            basic_reg  <= basic_next;
            detail_reg <= detail_next;
            echo_reg   <= echo_next;
            data_reg   <= data_next;
            sel_reg    <= sel_next;
            aux_en_reg <= ~(win_sup & ~snap_supp_reg); // R9
        end
    end

    // the code is sent once per supply episode, counted at the frame boundary
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sup_code_sent_reg <= 1'b0;
        end else if (~win_sup) begin
            sup_code_sent_reg <= 1'b0;
        end else if (cs_rise_i & sup_send_code) begin
            sup_code_sent_reg <= 1'b1; // R9
        end
    end

    assign basic_status_field_o    = basic_reg;
    assign detailed_status_field_o = detail_reg;
    assign source_echo_o           = echo_reg;
    assign data_field_o            = data_reg;
    assign data_sel_o              = sel_reg;
    assign aux_output_enable_o     = aux_en_reg;

    ////////////////////////////////////////////////////////////////////////
    a_capture_on_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
        !cs_rise_i |=> $stable(snap_reg))
        else $error("snapshot changed without chip-select rise");
    a_error_basic: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
        any_err |=> basic_status_field_o == `SDSE_ST_ERROR)
        else $error("basic status not error while error captured");
    a_noerr_detail: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
        !any_err |=> detailed_status_field_o == `SDSE_SF_NONE)
        else $error("detailed status set without error");
    a_class_none_data: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
        (any_err && cls_none) |=> (data_field_o == $past(sensor_data_i)
                                   && source_echo_o == $past(source_id_i)))
        else $error("low class error altered data or echo");
    a_memory_class: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        (snap_reg[`SDSE_SRC_UOTP] && snap_reg[`SDSE_SRC_FOTP:0] == '0)
        |=> (detailed_status_field_o == `SDSE_SF_MEMORY && source_echo_o == `SDSE_ECHO_ZERO))
        else $error("user otp error not encoded");
    a_rw_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
        (win[`SDSE_SRC_URW]) |=> data_field_o == $past(error_code_i))
        else $error("rw memory error code missing");
    a_factory_detail: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
        win[`SDSE_SRC_FOTP] |=> detailed_status_field_o == `SDSE_SF_MEMORY)
        else $error("factory otp error not encoded");
    a_test_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
        win_test |=> (data_field_o == `SDSE_DATA_ZERO && source_echo_o == `SDSE_ECHO_ZERO
                      && detailed_status_field_o == `SDSE_SF_MODE))
        else $error("test mode response not zero");
    a_supply_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
        (win_sup && !snap_tmr_reg) |=> (data_field_o == `SDSE_DATA_ZERO && !aux_output_enable_o)
                                     || $past(snap_supp_reg))
        else $error("supply error did not zero response");
    a_supply_suppr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
        (win_sup && snap_supp_reg) |=> data_sel_o == SDSE_DATA_ZEROS)
        else $error("suppressed supply error sent code");
    a_reset_detail: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        win[`SDSE_SRC_RESET] |=> detailed_status_field_o == `SDSE_SF_MODE)
        else $error("reset error not encoded");
    a_link_detail: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
        cls_link |=> (detailed_status_field_o == `SDSE_SF_LINK && data_sel_o == SDSE_DATA_ERRCODE))
        else $error("link error not encoded");
    a_lowest_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
        (snap_reg[`SDSE_SRC_CMD] && snap_reg[`SDSE_SRC_OSC]) |=> detailed_status_field_o == `SDSE_SF_LINK)
        else $error("priority order broken");
    // these also look one edge ahead, through the response register, except a_cmd_sticky, which reads cmd_err_reg
    a_cmd_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
        spi_cmd_err_i |=> cmd_err_reg)
        else $error("command error not held");
    a_clean_data: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
        !any_err |=> (data_field_o == $past(sensor_data_i) && source_echo_o == $past(source_id_i)))
        else $error("clean response altered data or echo");
    a_selftest_basic: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
        (!any_err && snap_st_reg) |=> basic_status_field_o == `SDSE_ST_SELFTEST)
        else $error("self-test not reported");
    a_user_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        win[`SDSE_SRC_UOTP] |=> (data_field_o == $past(error_code_i) && source_echo_o == `SDSE_ECHO_ZERO))
        else $error("user otp error code missing");
    a_factory_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
        win[`SDSE_SRC_FOTP] |=> (data_field_o == $past(error_code_i) && source_echo_o == `SDSE_ECHO_ZERO))
        else $error("factory otp error code missing");
    a_reset_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        win[`SDSE_SRC_RESET] |=> (data_field_o == $past(error_code_i) && source_echo_o == `SDSE_ECHO_ZERO))
        else $error("reset error code missing");
    a_link_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
        cls_link |=> (data_field_o == $past(error_code_i) && source_echo_o == `SDSE_ECHO_ZERO))
        else $error("link error code missing");
    a_supply_once: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
        (win_sup && sup_code_sent_reg) |=> data_sel_o == SDSE_DATA_ZEROS)
        else $error("supply error code repeated");
    a_supply_aux: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
        (win_sup && !snap_supp_reg) |=> !aux_output_enable_o)
        else $error("aux output left on during supply error");
    a_aux_restore: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
        !win_sup |=> aux_output_enable_o)
        else $error("aux output off without supply error");

    c_memory: cover property (@(posedge clk_i) disable iff (sys_rst_i) cls_mem);
    c_supply_code: cover property (@(posedge clk_i) disable iff (sys_rst_i) sup_send_code);
    c_test: cover property (@(posedge clk_i) disable iff (sys_rst_i) win_test);
    c_multi: cover property (@(posedge clk_i) disable iff (sys_rst_i) any_err && (snap_reg != win));
    c_supply_hold: cover property (@(posedge clk_i) disable iff (sys_rst_i) win_sup && snap_supp_reg);
endmodule
`default_nettype wire

// File: tb/sdse_spi_master_model.sv
`default_nettype none
module sdse_spi_master_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // request from the bench
    input  wire logic       start_i,
    input  wire logic       pair_i,
    input  wire logic [3:0] gap_i,
    // response status seen by the master
    input  wire logic [1:0] basic_status_field_i,
    input  wire logic [1:0] detailed_status_field_i,
    // towards the device, and back to the bench
    output logic            cs_rise_o,
    output logic            busy_o,
    output logic            keep_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    logic [1:0] left_reg;
    // a slow master waits gap_i cycles; pair_i closes two commands on consecutive cycles
    always_ff @(negedge clk_i) begin
        if (sys_rst_i) begin
            cs_rise_o <= 1'b0;
            busy_o    <= 1'b0;
            cnt_reg   <= 4'h0;
            left_reg  <= 2'h0;
        end else if (start_i && !busy_o) begin
            cs_rise_o <= 1'b0;
            busy_o    <= 1'b1;
            cnt_reg   <= gap_i;
            left_reg  <= pair_i ? 2'h2 : 2'h1;
        end else if (busy_o && cnt_reg != 4'h0) begin
            cs_rise_o <= 1'b0;
            cnt_reg   <= cnt_reg - 4'h1;
        end else begin
            cs_rise_o <= busy_o;
            left_reg  <= busy_o ? left_reg - 2'h1 : left_reg;
            busy_o    <= busy_o && (left_reg != 2'h1);
        end
    end
    // sensor data is only trusted while no error class is flagged
    assign keep_data_o = !(basic_status_field_i == 2'h3 && detailed_status_field_i != 2'h0);
endmodule
`default_nettype wire

// File: tb/tb.sv
`include "sdse_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdse_pkg::*;
    logic           clk, rst, cmd, supp, init, selft, start, pair, cs_rise, busy, aux;
    logic           e_aux, aux_known, code_sent, keep;
    logic [12:0]    flg;
    logic [2:0]     sid, echo;
    logic [15:0]    sdata, ecode, data;
    logic [3:0]     gap;
    logic [1:0]     basic, det, e_basic, e_det;
    sdse_data_sel_t sel, e_sel;
    int             last_w, num_errors, cmp_count;

    sdse_status_encoder i_dut (
        .clk_i(clk), .sys_rst_i(rst), .cs_rise_i(cs_rise),
        .osc_train_err_i(flg[0]), .signal_clip_flag_i(flg[1]), .offset_err_i(flg[2]), .temp_err_i(flg[3]),
        .user_bank_zero_err_i(flg[4]), .user_bank_one_err_i(flg[5]), .user_rw_bank_err_i(flg[6]),
        .factory_otp_err_i(flg[7]), .test_mode_flag_i(flg[8]), .supply_err_i(flg[9]),
        .supply_timer_expired_i(flg[10]), .device_reset_flag_i(flg[11]), .dout_line_err_i(flg[12]),
        .spi_cmd_err_i(cmd), .supply_error_suppress_i(supp), .init_done_i(init), .self_test_i(selft),
        .source_id_i(sid), .sensor_data_i(sdata), .error_code_i(ecode),
        .basic_status_field_o(basic), .detailed_status_field_o(det), .source_echo_o(echo),
        .data_field_o(data), .data_sel_o(sel), .aux_output_enable_o(aux)
    );
    sdse_spi_master_model i_master (
        .clk_i(clk), .sys_rst_i(rst), .start_i(start), .pair_i(pair), .gap_i(gap),
        .basic_status_field_i(basic), .detailed_status_field_i(det),
        .cs_rise_o(cs_rise), .busy_o(busy), .keep_data_o(keep)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200us;
        num_errors++;
        $display("watchdog expired before the tests ended");
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // index of the winning source, priority value minus one; -1 when clean
    function automatic int winner(input logic [12:0] f, input logic c);
        logic [10:0] pv;
        pv = {f[0], f[1] | f[2], f[3], f[4] | f[5], f[6], f[7], f[8], f[9], f[11], f[12], c};
        for (int i = 0; i < 11; i++) begin
            if (pv[i]) return i;
        end
        return -1;
    endfunction
    task automatic predict(input logic [12:0] f, input logic c);
        int w;
        w = winner(f, c);
        e_basic = (w >= 0) ? `SDSE_ST_ERROR : selft ? `SDSE_ST_SELFTEST : init ? `SDSE_ST_NORMAL : `SDSE_ST_INIT;
        e_det = (w < 0 || w > 7) ? `SDSE_SF_NONE : (w > 4) ? `SDSE_SF_MEMORY : (w > 1) ? `SDSE_SF_MODE : `SDSE_SF_LINK;
        e_sel = (w < 0 || w > 7) ? SDSE_DATA_SENSOR : (w == 4) ? SDSE_DATA_ZEROS : SDSE_DATA_ERRCODE;
        // one error code per supply episode, and only once the monitor timer ran out
        if (w == 3) begin
            e_sel = (f[10] && !supp && !code_sent) ? SDSE_DATA_ERRCODE : SDSE_DATA_ZEROS;
            code_sent = code_sent | (e_sel == SDSE_DATA_ERRCODE);
        end else begin
            code_sent = 1'b0;
        end
        // a supply error masked by a stronger one leaves aux unpredictable here
        aux_known = !f[9] || supp || w == 3;
        e_aux = !(f[9] && !supp);
        last_w = w;
    endtask
    task automatic check_fields();
        logic [15:0] e_data;
        e_data = (e_sel == SDSE_DATA_SENSOR) ? sdata : (e_sel == SDSE_DATA_ERRCODE) ? ecode : `SDSE_DATA_ZERO;
        cmp("basic", 16'(e_basic), 16'(basic));
        cmp("detailed", 16'(e_det), 16'(det));
        cmp("select", 16'(e_sel), 16'(sel));
        cmp("data", e_data, data);
        cmp("echo", (last_w < 0 || last_w > 7) ? 16'(sid) : 16'h0000, 16'(echo));
        if (aux_known) cmp("aux", 16'(e_aux), 16'(aux));
        cmp("keep", 16'(!(e_basic == `SDSE_ST_ERROR && e_det != `SDSE_SF_NONE)), 16'(keep));
    endtask
    task automatic run(input logic [12:0] f, input logic c, input logic two, input logic [3:0] g);
        logic [1:0] d1;
        int         n;
        @(negedge clk);
        flg = f;
        cmd = c;
        @(negedge clk);
        cmd = 1'b0;
        repeat (3) @(negedge clk);
        d1 = e_det;
        predict(f, c);
        if (two) begin
            d1 = e_det;
            predict(f, 1'b0);
        end
        pair <= two;
        gap <= g;
        start <= 1'b1;
        @(negedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy && n < 40);
        @(negedge clk);
        cmp("early detailed", 16'(d1), 16'(det));
        @(negedge clk);
        check_fields();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h675B));
        rst = 1'b1;
        {flg, cmd, supp, init, selft, start, pair, gap, code_sent, e_det} = '0;
        {num_errors, cmp_count} = '0;
        last_w = -1;
        sid = 3'h5;
        sdata = 16'h1234;
        ecode = 16'hE00F;
        repeat (6) @(negedge clk);
        cmp("reset fields", 16'h0001, 16'({basic, det, echo, sel, aux}));
        cmp("reset data", 16'h0000, data);
        rst = 1'b0;
        for (int i = 0; i < 3; i++) begin
            init = (i > 0);
            selft = (i > 1);
            run(13'h0000, 1'b0, 1'b0, 4'h2);
        end
        for (int i = 0; i <= 13; i++) begin
            run((i < 13) ? 13'(1 << i) : 13'h0000, i == 13, 1'b0, 4'h0);
        end
        for (int i = 0; i < 7; i++) begin
            supp = (i == 6);
            run((i == 3 || i == 5) ? 13'h0000 : 13'h0600, 1'b0, 1'b0, 4'h1);
        end
        run(13'h0000, 1'b1, 1'b1, 4'h3);
        run(13'h1FFF, 1'b1, 1'b0, 4'h7);
        for (int n = 0; n < 250; n++) begin
            if (last_w != 3) supp = 1'($urandom);
            init = 1'($urandom);
            selft = 1'($urandom);
            sid = 3'($urandom);
            sdata = 16'($urandom);
            ecode = 16'($urandom);
            run(13'($urandom & $urandom & $urandom),
                ($urandom % 6) == 0, ($urandom % 5) == 0, 4'($urandom % 8));
        end
        conclude();
    end
endmodule
`default_nettype wire
